// *** via_pkg.sv ***
// Purpose: Shared constants and carrier types for the vectored interrupt arbiter.
// Assumes: 15-bit program address space, 8-bit opcodes and program bytes.
// Notes:   Register offsets are byte addresses on a 32-bit AXI4-Lite bus.
package via_pkg;
    localparam int ADDR_W = 15;
    localparam int NSRC = 16;
    localparam logic [7:0] TRAP_OPCODE = 8'h00;
    localparam logic [7:0] VIS_OPCODE = 8'hB4;
    localparam logic [7:0] CLEAR_TRAP_PENDING_INSTR_OPCODE = 8'hB5;
    localparam logic [7:0] VEC_BASE = 8'hE0;
    localparam logic [ADDR_W-1:0] ACK_ADDR = 15'h00FF;
    localparam logic [2:0] ACK_CYCLES = 3'h7;
    localparam logic [15:0] RESERVED_MASK = 16'h410D;
    localparam logic [5:0] OFF_ENABLE = 6'h00;
    localparam logic [5:0] OFF_PENDING = 6'h04;
    localparam logic [5:0] OFF_STATUS = 6'h08;
    localparam logic [5:0] OFF_PC = 6'h0C;
    localparam logic [5:0] OFF_TRAP_CTL = 6'h10;
    localparam int ST_TRAP = 0;
    localparam int ST_GIE = 1;
    localparam int ST_BUSY = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ACK = 3'b001,
        S_VHI = 3'b010,
        S_VLO = 3'b011,
        S_DONE = 3'b100
    } seq_state_t;

    typedef struct packed {
        logic                  valid;
        logic [7:0]            opcode;
        logic [ADDR_W-1:0]     addr;
    } instr_t;

    typedef struct packed {
        logic                  req;
        logic [ADDR_W-1:0]     addr;
    } pmem_req_t;
endpackage

// *** vector_rom.sv ***
// Purpose: Small program memory holding the vector table, registered read data.
// Assumes: Reads beyond the programmed depth return zero bytes.
// Notes:   Written by software through the register bus for table setup.
`timescale 1ns/1ps
`default_nettype none
module vector_rom (
    // Clock; no reset.
    input  wire logic                       aclk,
    // Write port.
    input  wire logic                       we,
    input  wire logic [via_pkg::ADDR_W-1:0] waddr,
    input  wire logic [7:0]                 wdata,
    // Read port.
    input  wire logic [via_pkg::ADDR_W-1:0] raddr,
    output logic      [7:0]                 rdata
);
    import via_pkg::*;
    logic [7:0] mem [0:1023];

    always_ff @(posedge aclk) begin
        if (we && waddr < 15'd1024) begin
            mem[waddr[9:0]] <= wdata;
        end
        // Unprogrammed space reads as zero, which decodes as a trap.
        if (raddr < 15'd1024) begin
            rdata <= mem[raddr[9:0]];
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// *** vectored_interrupt_arbiter.sv ***
// Purpose: Vector arbitration, vector fetch and trap pending flag of the core.
// Assumes: The sequencer presents one instruction at a time and waits for done.
// Notes:   Registers via AXI4-Lite; enable/pending bits stand in for peripherals.
// Summary of operation
// RL1: Vector-select samples active sources in its first cycle, gives even byte E0..FE.
// RL2: The arbiter byte replaces only the low PC byte; high byte kept.
// RL3: Vector is then read from program memory and loaded into the PC.
// RL4: Active trap always yields FE.
// RL5: External pin without trap yields FA; lower sources follow rank order.
// RL6: With nothing active the arbiter yields E0.
// RL7: Ranking FE trap down to E2 Port L edge, E0 default.
// RL8: Table sits in the instruction's page, next page if at page end.
// RL9: Trap sets the pending flag; reset clears it; software cannot reach it.
// RL10: Pending flag is not in the data memory map.
// RL11: Clear-trap instruction always clears the flag; only reset otherwise clears.
// RL12: Trap opcode loaded into instruction register always raises a trap.
// RL13: Reads past programmed memory give zero, decoded as the trap opcode.
// RL14: Trap leaves global enable alone; pending flag blocks maskable acknowledge.
// RL15: Only another trap may preempt a running trap routine.
// RL16: Trap entry pushes the trap opcode's own address.
// RL17: Pending indication is one flag, not a nesting counter.
// RL18: Trap opcode is the all-zero byte.
// RL19: Maskable source is active only with enable and pending both set.
// RL20: Acknowledge clears global enable, pushes address, jumps to 00FF in seven cycles.
// RL21: Vector is a 15-bit target, high byte at lower address.
// RL22: Vector fetch reads high then low, then writes PC once.
// RL23: Reserved positions never count as active.
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_arbiter (
    // Clock and reset.
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    // Instruction sequencer.
    input  wire via_pkg::instr_t            instr,
    output logic                            instr_done,
    output logic                            pc_load,
    output logic      [via_pkg::ADDR_W-1:0] pc_out,
    output logic                            push_valid,
    output logic      [via_pkg::ADDR_W-1:0] push_addr,
    output logic                            irq_ack,
    // Peripheral request pulses, one bit per rank slot.
    input  wire logic [via_pkg::NSRC-1:0]   src_event,
    // AXI4-Lite slave.
    input  wire logic [5:0]                 s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic      [1:0]                 s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [5:0]                 s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic      [31:0]                s_axi_rdata,
    output logic      [1:0]                 s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready
);
    import via_pkg::*;

    typedef struct packed {
        seq_state_t         st;
        logic [2:0]         cnt;
        logic               trap_pend;
        logic               global_irq_enable;
        logic [15:0]        enable;
        logic [15:0]        pending;
        logic [ADDR_W-1:0]  pc;
        logic [ADDR_W-1:0]  vaddr;
        logic [6:0]         vhi;
        logic [7:0]         vec_byte;
        logic               done;
        logic               pc_load;
        logic               push_v;
        logic [ADDR_W-1:0]  push_a;
        logic               ack;
        logic               aw_got;
        logic               w_got;
        logic [5:0]         aw_a;
        logic [31:0]        w_d;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               rvalid;
        logic [31:0]        rdata;
        logic [1:0]         rresp;
        logic               rom_we;
        logic [ADDR_W-1:0]  rom_wa;
        logic [7:0]         rom_wd;
    } state_t;

    state_t state_reg;
    state_t state_next;
    logic [7:0] rom_rdata;
    logic [15:0] active;
    logic [7:0] arb_byte;
    logic [15:0] src_ok;

    // Priority encoder shared by arbitration and the status read.
    function automatic logic [7:0] arbitrate(input logic [15:0] act);
        logic [7:0] b;
        b = VEC_BASE;
        for (int i = 0; i < NSRC; i++) begin
            if (act[i]) begin
                b = VEC_BASE + 8'(2 * i);
            end
        end
        return b;
    endfunction

    // Bit 15 is the trap, bit 0 the default slot; reserved slots are forced off.
    assign active = ({state_reg.trap_pend, 15'h0000}
                    | (state_reg.enable & state_reg.pending)) & ~RESERVED_MASK; // see RL19 RL23
    assign arb_byte = arbitrate(active); // see RL1 RL4 RL5 RL6 RL7
    // The trap slot is raised only by the opcode, never by a peripheral line.
    assign src_ok = src_event & {1'b0, ~RESERVED_MASK[NSRC-2:0]}; // see RL9 RL23

    vector_rom u_rom (
        .aclk  (aclk),
        .we    (state_reg.rom_we),
        .waddr (state_reg.rom_wa),
        .wdata (state_reg.rom_wd),
        .raddr (state_reg.vaddr),
        .rdata (rom_rdata)
    );

    always_comb begin
        logic [5:0] a;
        logic [31:0] d;
        a = '0;
        d = '0;
        state_next = state_reg;
        state_next.done = 1'b0;
        state_next.pc_load = 1'b0;
        state_next.push_v = 1'b0;
        state_next.ack = 1'b0;
        state_next.rom_we = 1'b0;
        // Peripheral events set pending bits; reserved slots stay clear.
        state_next.pending = state_reg.pending | src_ok; // see RL23

        unique case (state_reg.st)
            S_IDLE: begin
                // The edge that shows done still sees the finished request held.
                if (instr.valid && !state_reg.done) begin
                    state_next.pc = instr.addr;
                    if (instr.opcode == TRAP_OPCODE) begin // see RL12 RL13 RL18
                        state_next.trap_pend = 1'b1; // see RL9 RL15
                        state_next.push_v = 1'b1;
                        state_next.push_a = instr.addr; // see RL16
                        state_next.pc = ACK_ADDR;
                        state_next.pc_load = 1'b1;
                        state_next.done = 1'b1; // see RL14
                    end else if (instr.opcode == CLEAR_TRAP_PENDING_INSTR_OPCODE) begin
                        state_next.trap_pend = 1'b0; // see RL11 RL17
                        state_next.done = 1'b1;
                    end else if (instr.opcode == VIS_OPCODE) begin
                        // Page of the table: next page when at the last address.
                        state_next.vaddr = {instr.addr[ADDR_W-1:8]
                            + 7'(instr.addr[7:0] == 8'hFF), arb_byte}; // see RL2 RL8
                        state_next.st = S_VHI;
                    end else begin
                        state_next.done = 1'b1;
                    end
                end else if (!instr.valid && state_reg.global_irq_enable && !state_reg.trap_pend
                             && |active[14:1]) begin // see RL14 RL15
                    state_next.global_irq_enable = 1'b0; // see RL20
                    state_next.cnt = ACK_CYCLES - 3'h1;
                    state_next.st = S_ACK;
                end
            end
            S_ACK: begin
                if (state_reg.cnt == 3'h1) begin
                    state_next.push_v = 1'b1;
                    state_next.push_a = state_reg.pc;
                    state_next.pc = ACK_ADDR;
                    state_next.pc_load = 1'b1;
                    state_next.ack = 1'b1;
                    state_next.st = S_IDLE;
                end
                state_next.cnt = state_reg.cnt - 3'h1; // see RL20
            end
            S_VHI: begin
                // High-byte address is presented now; its byte arrives in S_VLO.
                state_next.vaddr = state_reg.vaddr + 15'h0001;
                state_next.st = S_VLO;
            end
            S_VLO: begin
                state_next.vhi = rom_rdata[6:0]; // see RL21 RL22
                state_next.st = S_DONE;
            end
            S_DONE: begin
                state_next.pc = {state_reg.vhi, rom_rdata}; // see RL3 RL22
                state_next.pc_load = 1'b1;
                state_next.done = 1'b1;
                state_next.st = S_IDLE;
            end
            default: begin
                state_next.st = S_IDLE;
            end
        endcase

        // Write channel: take address and data in either order.
        if (s_axi_awvalid && !state_reg.aw_got) begin
            state_next.aw_got = 1'b1;
            state_next.aw_a = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state_reg.w_got) begin
            state_next.w_got = 1'b1;
            state_next.w_d = s_axi_wdata;
        end
        if (state_reg.aw_got && state_reg.w_got && !state_reg.bvalid) begin
            state_next.aw_got = 1'b0;
            state_next.w_got = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = RESP_OKAY;
            d = state_reg.w_d;
            unique case ({state_reg.aw_a[5:2], 2'b00})
                OFF_ENABLE: state_next.enable = d[15:0];
                // Write one clears; a same-cycle event still sets.
                OFF_PENDING: state_next.pending = (state_reg.pending & ~d[15:0])
                                                 | src_ok;
                OFF_STATUS: state_next.global_irq_enable = d[ST_GIE];
                OFF_TRAP_CTL: begin
                    state_next.rom_we = 1'b1;
                    state_next.rom_wa = d[ADDR_W+7:8];
                    state_next.rom_wd = d[7:0];
                end
                default: state_next.bresp = RESP_SLVERR;
            endcase
        end
        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end

        // Read channel; the trap flag is never exposed here.
        if (s_axi_arvalid && !state_reg.rvalid) begin // see RL10
            a = {s_axi_araddr[5:2], 2'b00};
            state_next.rvalid = 1'b1;
            state_next.rresp = RESP_OKAY;
            unique case (a)
                OFF_ENABLE: state_next.rdata = {16'h0000, state_reg.enable};
                OFF_PENDING: state_next.rdata = {16'h0000, state_reg.pending};
                OFF_STATUS: state_next.rdata = {16'h0000, arb_byte, 5'h00,
                                                state_reg.st != S_IDLE,
                                                state_reg.global_irq_enable, 1'b0};
                OFF_PC: state_next.rdata = {17'h00000, state_reg.pc};
                default: begin
                    state_next.rdata = 32'h0000_0000;
                    state_next.rresp = RESP_SLVERR;
                end
            endcase
        end else if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign instr_done = state_reg.done;
    assign pc_load = state_reg.pc_load;
    assign pc_out = state_reg.pc;
    assign push_valid = state_reg.push_v;
    assign push_addr = state_reg.push_a;
    assign irq_ack = state_reg.ack;
    assign s_axi_awready = !state_reg.aw_got;
    assign s_axi_wready = !state_reg.w_got;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_arready = !state_reg.rvalid;
    assign s_axi_rvalid = state_reg.rvalid;
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;

    // Assertions.
    property p_trap_sets;
        @(posedge aclk) disable iff (!aresetn)
        (state_reg.st == S_IDLE && instr.valid && !instr_done && instr.opcode == TRAP_OPCODE)
            |=> state_reg.trap_pend && push_valid && push_addr == $past(instr.addr);
    endproperty
    a_trap_sets: assert property (p_trap_sets) else $error("trap not taken"); // see RL12

    property p_clear_trap_pending_instr_clears;
        @(posedge aclk) disable iff (!aresetn)
        (state_reg.st == S_IDLE && instr.valid && !instr_done && instr.opcode == CLEAR_TRAP_PENDING_INSTR_OPCODE)
            |=> !state_reg.trap_pend;
    endproperty
    a_clear_trap_pending_instr_clears: assert property (p_clear_trap_pending_instr_clears) else $error("flag not cleared"); // see RL11

    property p_trap_fe;
        @(posedge aclk) disable iff (!aresetn)
        state_reg.trap_pend |-> arb_byte == 8'hFE;
    endproperty
    a_trap_fe: assert property (p_trap_fe) else $error("trap not FE"); // see RL4

    property p_no_ack_trap;
        @(posedge aclk) disable iff (!aresetn)
        state_reg.trap_pend && state_reg.st == S_IDLE |=> state_reg.st != S_ACK;
    endproperty
    a_no_ack_trap: assert property (p_no_ack_trap) else $error("ack under trap"); // see RL14

    sequence s_ack_start;
        state_reg.st == S_IDLE && !instr.valid && state_reg.global_irq_enable
            && !state_reg.trap_pend && |active[14:1];
    endsequence

    sequence s_ack_end;
        irq_ack && push_valid && pc_out == ACK_ADDR && !state_reg.global_irq_enable;
    endsequence

    // The start edge and six countdown edges make seven; outputs show after the last.
    property p_ack_seven;
        @(posedge aclk) disable iff (!aresetn)
        s_ack_start |-> ##7 s_ack_end;
    endproperty
    a_ack_seven: assert property (p_ack_seven) else $error("ack timing"); // see RL20

    property p_vis_fetch;
        @(posedge aclk) disable iff (!aresetn)
        (state_reg.st == S_IDLE && instr.valid && !instr_done && instr.opcode == VIS_OPCODE)
            |-> ##4 (pc_load && instr_done);
    endproperty
    a_vis_fetch: assert property (p_vis_fetch) else $error("vector fetch"); // see RL22

    property p_page;
        @(posedge aclk) disable iff (!aresetn)
        (state_reg.st == S_IDLE && instr.valid && !instr_done && instr.opcode == VIS_OPCODE
         && instr.addr[7:0] != 8'hFF)
            |=> state_reg.vaddr[ADDR_W-1:8] == $past(instr.addr[ADDR_W-1:8]);
    endproperty
    a_page: assert property (p_page) else $error("wrong page"); // see RL8

    property p_reserved;
        @(posedge aclk) disable iff (!aresetn)
        (state_reg.pending & (RESERVED_MASK | 16'h8000)) == 16'h0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved active"); // see RL23

    property p_even;
        @(posedge aclk) disable iff (!aresetn)
        !arb_byte[0] && arb_byte >= VEC_BASE;
    endproperty
    a_even: assert property (p_even) else $error("odd vector"); // see RL1
endmodule
`default_nettype wire

// *** via_seq_model.sv ***
// Purpose: Stand-in for the instruction sequencer and the peripheral request sources.
// Assumes: One instruction at a time; valid is held until the block reports done.
// Notes:   Results of the last instruction are kept for the bench to compare.
`timescale 1ns/1ps
`default_nettype none
module via_seq_model (
    // Clock.
    input  wire logic                       aclk,
    // Sequencer side.
    output var  via_pkg::instr_t            instr,
    input  wire logic                       instr_done,
    input  wire logic                       pc_load,
    input  wire logic [via_pkg::ADDR_W-1:0] pc_out,
    input  wire logic                       push_valid,
    input  wire logic [via_pkg::ADDR_W-1:0] push_addr,
    // Peripheral request lines.
    output var  logic [via_pkg::NSRC-1:0]   src_event
);
    import via_pkg::*;
    logic              got_load;
    logic              got_push;
    logic [ADDR_W-1:0] got_pc;
    logic [ADDR_W-1:0] got_push_addr;
    int                timeouts = 0;

    initial begin
        instr = '0;
        src_event = '0;
    end

    // Valid stands until the edge that samples done; the block ignores it there.
    task automatic exec(input logic [7:0] op, input logic [ADDR_W-1:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        instr <= {1'b1, op, a};
        do begin
            @(posedge aclk);
            n++;
        end while (instr_done !== 1'b1 && n < 40);
        if (n >= 40) timeouts++;
        got_load = pc_load;
        got_pc = pc_out;
        got_push = push_valid;
        got_push_addr = push_addr;
        instr <= {1'b0, ~op, ~a};
    endtask

    task automatic pulse(input logic [NSRC-1:0] m);
        @(posedge aclk);
        src_event <= m;
        @(posedge aclk);
        src_event <= '0;
    endtask
endmodule
`default_nettype wire

// *** vectored_interrupt_arbiter_tb_top.sv ***
// Purpose: Self-checking bench for arbitration, vector fetch, trap flag and acknowledge.
// Assumes: Vector memory of 1024 bytes; pages 1 to 3 hold tables.
// Notes:   A behavioural model of enables, pendings and trap flag gives expectations.
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_arbiter_tb_top;
    import via_pkg::*;
    logic aclk = 0, aresetn = 0;
    logic instr_done, pc_load, push_valid, irq_ack;
    logic [ADDR_W-1:0] pc_out, push_addr;
    instr_t instr;
    logic [NSRC-1:0] src_event;
    logic [5:0] awaddr = '0, araddr = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = '0, rdata;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rd;
    logic [15:0] en, pend;
    int bad_count = 0, total_checks = 0, acks = 0;

    vectored_interrupt_arbiter dut (.aclk(aclk), .aresetn(aresetn), .instr(instr),
        .instr_done(instr_done), .pc_load(pc_load), .pc_out(pc_out),
        .push_valid(push_valid), .push_addr(push_addr), .irq_ack(irq_ack),
        .src_event(src_event), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    via_seq_model seq (.aclk(aclk), .instr(instr), .instr_done(instr_done),
        .pc_load(pc_load), .pc_out(pc_out), .push_valid(push_valid),
        .push_addr(push_addr), .src_event(src_event));

    initial begin
        forever #4 aclk = ~aclk;
    end
    always @(posedge aclk) if (irq_ack === 1'b1) acks++;

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count + seq.timeouts);
        if (bad_count + seq.timeouts == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_pc(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp);
        chk_word({17'h0, got}, {17'h0, exp});
    endtask
    task automatic axw(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 0;
            if (wready === 1'b1) wvalid <= 0;
            n++;
        end while (bvalid !== 1'b1 && n < 50);
        if (n >= 50) bad_count++;
        r = bresp;
        bready <= 0;
    endtask
    task automatic axr(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 0;
            n++;
        end while (rvalid !== 1'b1 && n < 50);
        if (n >= 50) bad_count++;
        d = rdata;
        r = rresp;
        rready <= 0;
    endtask

    // Byte stored at each vector-memory address; vectors use 7 + 8 bits.
    function automatic logic [7:0] vb(input logic [14:0] a);
        return a[7:0] ^ 8'h3C ^ {a[9:8], 6'h15};
    endfunction
    function automatic logic [14:0] vexp(input logic [14:0] a, input int idx);
        logic [6:0] page;
        logic [14:0] hi;
        logic [7:0] b;
        page = a[14:8] + 7'(a[7:0] == 8'hFF);
        hi = {page, 8'hE0 + 8'(2 * idx)};
        if (hi >= 15'd1024) return '0;
        b = vb(hi);
        return {b[6:0], vb(hi + 15'h1)};
    endfunction
    function automatic int top(input logic [15:0] act);
        for (int i = 15; i > 0; i--) if (act[i]) return i;
        return 0;
    endfunction
    task automatic vector_select_instr(input logic [14:0] a, input logic trap);
        int idx;
        idx = trap ? 15 : top(en & pend & ~RESERVED_MASK & 16'h7FFF);
        seq.exec(VIS_OPCODE, a);
        chk_word({31'h0, seq.got_load}, 32'h1);
        chk_pc(seq.got_pc, vexp(a, idx));
    endtask
    task automatic set_en(input logic [15:0] v);
        en = v;
        axw(OFF_ENABLE, {16'h0, v}, resp);
        chk_word({30'h0, resp}, {30'h0, RESP_OKAY});
    endtask
    task automatic clr_pend();
        pend = '0;
        axw(OFF_PENDING, 32'hFFFF, resp);
    endtask

    initial begin
        #200_000;
        bad_count++;
        stop_test();
    end

    initial begin
        logic [14:0] ad;
        logic [15:0] ev;
        void'($urandom(32'hf317));
        en = '0;
        pend = '0;
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        axr(OFF_STATUS, rd, resp);
        chk_word({31'h0, rd[ST_GIE]}, 32'h0);
        for (int p = 1; p < 4; p++)
            for (int o = 8'hE0; o <= 8'hFF; o++) begin
                ad = {7'(p), 8'(o)};
                axw(OFF_TRAP_CTL, {9'h0, ad, vb(ad)}, resp);
            end
        vector_select_instr(15'h0150, 0);
        vector_select_instr(15'h01FF, 0);
        vector_select_instr(15'h0510, 0);
        set_en(16'hFFFF);
        for (int i = 0; i < 16; i++) begin
            seq.pulse(16'(1 << i));
            pend[i] = 1'b1;
            axr(OFF_PENDING, rd, resp);
            chk_word(rd, {16'h0, pend & ~RESERVED_MASK & 16'h7FFF});
            vector_select_instr(15'h01A0, 0);
            clr_pend();
        end
        for (int k = 0; k < 12; k++) begin
            set_en(16'($urandom));
            ev = 16'($urandom);
            seq.pulse(ev);
            pend = pend | ev;
            vector_select_instr({7'($urandom % 2 + 1), 8'($urandom)}, 0);
            if (k % 3 == 2) clr_pend();
        end
        set_en(16'hFFFF);
        seq.pulse(16'h2000);
        pend = 16'h2000;
        seq.exec(TRAP_OPCODE, 15'h0123);
        chk_word({31'h0, seq.got_push}, 32'h1);
        chk_pc(seq.got_push_addr, 15'h0123);
        chk_pc(seq.got_pc, ACK_ADDR);
        vector_select_instr(15'h0140, 1);
        axr(OFF_STATUS, rd, resp);
        chk_word({31'h0, rd[ST_GIE]}, 32'h0);
        axw(OFF_STATUS, 32'h2, resp);
        acks = 0;
        repeat (20) @(posedge aclk);
        seq.exec(TRAP_OPCODE, 15'h0144);
        vector_select_instr(15'h0146, 1);
        chk_word(32'(acks), 32'h0);
        seq.exec(CLEAR_TRAP_PENDING_INSTR_OPCODE, 15'h0148);
        repeat (12) @(posedge aclk);
        chk_word(32'(acks), 32'h1);
        chk_pc(pc_out, ACK_ADDR);
        axr(OFF_STATUS, rd, resp);
        chk_word({31'h0, rd[ST_GIE]}, 32'h0);
        vector_select_instr(15'h0150, 0);
        axw(6'h3C, 32'h1, resp);
        chk_word({30'h0, resp}, {30'h0, RESP_SLVERR});
        axr(6'h3C, rd, resp);
        chk_word({30'h0, resp}, {30'h0, RESP_SLVERR});
        chk_word(rd, 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
